// >>> aacc_analog_model.sv
// aacc_analog_model: analog pins and sample-and-hold beside aacc_top
// assumes the bench gives one 10-bit level per implemented channel
`timescale 1ns/100ps
`default_nettype none
module aacc_analog_model (
  // clock
  input  wire logic        pclk,
  // bench side
  input  wire logic [69:0] chan_levels,
  input  wire logic [6:0]  pin_drive,
  // block side
  input  wire logic [2:0]  mux_select,
  input  wire logic        mux_valid,
  input  wire logic        sh_sample,
  input  wire logic        conv_active,
  output logic      [9:0]  sample_value,
  output logic      [6:0]  pin_level
);
  logic [9:0] held;           // charge on the hold capacitor
  logic       late;           // one cycle of hold after conversion
  logic [9:0] churn = 10'h155; // junk outside conversion
  // capacitor follows the selected pin only while tracking
  always @(posedge pclk)
  begin
    if (sh_sample)
      held <= mux_valid ? chan_levels[mux_select * 10 +: 10] : 10'h3ff;
    late  <= conv_active;
    churn <= churn + 10'h0ab;
  end
  // held level only while the converter can look at it
  assign sample_value = (conv_active | late) ? held : churn;
  // pins pass straight through
  assign pin_level = pin_drive;
endmodule : aacc_analog_model
`default_nettype wire

// >>> aacc_pkg.sv
// aacc_pkg: register map, field layout, reset values and timing counts
// assumes a 32-bit APB slave, one register per aligned word
package aacc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_PINCFG  = 8'h04;
  localparam logic [7:0] ADDR_CTRL2   = 8'h08;
  localparam logic [7:0] ADDR_RES_HI  = 8'h0C;
  localparam logic [7:0] ADDR_RES_LO  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  // control 0 fields
  localparam int CTRL0_ON   = 0;
  localparam int CTRL0_GO   = 1;
  localparam int CTRL0_CHS  = 2;
  localparam int CTRL0_REF  = 6;
  // control 2 fields
  localparam int CTRL2_CLK  = 0;
  localparam int CTRL2_ACQ  = 3;
  localparam int CTRL2_FMT  = 7;
  // status register: bit 0 done flag, write 1 clears
  localparam int STAT_DONE  = 0;
  // reset values
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [7:0] PINCFG_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  // reserved-bit masks (reserved bits read zero)
  localparam logic [7:0] CTRL0_MASK  = 8'hDF;
  localparam logic [7:0] PINCFG_MASK = 8'h7F;
  localparam logic [7:0] CTRL2_MASK  = 8'hBF;
  // channel codes
  localparam logic [2:0] CHAN_NONE  = 3'h7;
  // conversion and wait lengths in bit periods
  localparam logic [4:0] CONV_PERIODS = 5'h0B;
  localparam logic [4:0] WAIT_PERIODS = 5'h02;
  // instruction cycle: four oscillator cycles
  localparam logic [1:0] TCY_CLOCKS   = 2'h3;
  // full-scale result
  localparam logic [9:0] FULL_SCALE   = 10'h3FF;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DLY   = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011,
    ST_WAIT  = 3'b100
  } aacc_state_t;
endpackage : aacc_pkg

// >>> aacc_top.sv
// aacc_top: converter control, sequencer and APB register file
// assumes APB master on pclk; analog side returns a 10-bit sample value
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module aacc_top
  import aacc_pkg::*;
#(
  parameter int RC_DIV = 500 // private RC clock divider, pclk cycles
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog side
  input  wire logic [9:0]  sample_value, // converter result bits
  input  wire logic [6:0]  pin_level,    // raw digital pin levels
  output logic      [2:0]  mux_select,   // channel to sample-and-hold
  output logic             mux_valid,    // selected channel implemented
  output logic             sh_sample,    // sample-and-hold tracking
  output logic             conv_active,  // converting
  output logic      [1:0]  ref_select,   // reference choice
  output logic             converter_on, // module powered
  output logic      [6:0]  pin_digital_in, // gated digital inputs
  output logic             conv_done_flag  // sticky completion flag
);

  // all state except the result pair in one struct
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  pincfg;
    logic [7:0]  ctrl2;
    logic        done;
    aacc_state_t st;
    logic [6:0]  div_cnt;   // oscillator prescale
    logic [9:0]  rc_cnt;    // RC clock divider
    logic [1:0]  dly_cnt;   // instruction-cycle delay
    logic [4:0]  per_cnt;   // bit periods left
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  pin_in;
    logic [2:0]  mux;
    logic        mux_ok;
    logic        shs;
    logic        conv;
  } aacc_reg_t;

  aacc_reg_t r;      // current state
  aacc_reg_t next_r; // next state
  // result pair lives apart: it has no reset at all
  logic [7:0] res_hi;      // result high byte
  logic [7:0] res_lo;      // result low byte
  logic [7:0] next_res_hi; // next result high byte
  logic [7:0] next_res_lo; // next result low byte

  // acquisition code to bit periods
  function automatic logic [4:0] acq_periods(input logic [2:0] c);
    case (c)
      3'h0:    acq_periods = 5'h00;
      3'h1:    acq_periods = 5'h02;
      3'h2:    acq_periods = 5'h04;
      3'h3:    acq_periods = 5'h06;
      3'h4:    acq_periods = 5'h08;
      3'h5:    acq_periods = 5'h0C;
      3'h6:    acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction : acq_periods

  // clock code to pclk divider mask; zero marks RC
  function automatic logic [6:0] clk_mask(input logic [2:0] c);
    case (c)
      3'h0:    clk_mask = 7'h01;
      3'h1:    clk_mask = 7'h07;
      3'h2:    clk_mask = 7'h1F;
      3'h4:    clk_mask = 7'h03;
      3'h5:    clk_mask = 7'h0F;
      3'h6:    clk_mask = 7'h3F;
      default: clk_mask = 7'h00;
    endcase
  endfunction : clk_mask

  // register map decode, used by the error path only
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CTRL0)  || (a == ADDR_PINCFG) ||
                (a == ADDR_CTRL2)  || (a == ADDR_RES_HI) ||
                (a == ADDR_RES_LO) || (a == ADDR_STATUS);
  endfunction : is_mapped

  logic       wr_en;   // apb write strobe
  logic       rd_en;   // apb read strobe, setup phase
  logic       is_rc;   // RC clock chosen
  logic       tick;    // one bit period elapsed
  logic [9:0] value;   // result for this conversion
  logic       go_wr;   // software writes go high
  logic       go_clr;  // software writes go low

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // next-state logic
  always_comb
  begin
    next_r = r;
    next_res_hi = res_hi;
    next_res_lo = res_lo;
    is_rc  = (clk_mask(r.ctrl2[CTRL2_CLK +: 3]) == 7'h00);
    tick   = 1'b0;
    value  = (r.ctrl0[CTRL0_CHS +: 3] == CHAN_NONE) ? FULL_SCALE
                                                    : sample_value;
    go_wr  = wr_en && paddr == ADDR_CTRL0 && pwdata[CTRL0_GO];
    go_clr = wr_en && paddr == ADDR_CTRL0 && !pwdata[CTRL0_GO];
    // bit-period tick from selected source
    if (is_rc)
    begin
      if (r.rc_cnt == 10'(RC_DIV - 1))
      begin
        next_r.rc_cnt = 10'h000;
        tick          = 1'b1;
      end
      else
        next_r.rc_cnt = r.rc_cnt + 10'h001;
    end
    else
    begin
      next_r.rc_cnt = 10'h000;
      next_r.div_cnt = r.div_cnt + 7'h01;
      tick = ((r.div_cnt & clk_mask(r.ctrl2[CTRL2_CLK +: 3]))
              == clk_mask(r.ctrl2[CTRL2_CLK +: 3]));
    end
    // register writes
    next_r.pready  = psel & ~penable;
    // error decided at setup so it stands with pready
    next_r.pslverr = psel & ~penable & ~is_mapped(paddr);
    if (wr_en)
    begin
      case (paddr)
        ADDR_CTRL0:  next_r.ctrl0 = pwdata[7:0] & CTRL0_MASK;
        ADDR_PINCFG: next_r.pincfg = pwdata[7:0] & PINCFG_MASK;
        ADDR_CTRL2:  next_r.ctrl2 = pwdata[7:0] & CTRL2_MASK;
        ADDR_RES_HI: next_res_hi = pwdata[7:0];
        ADDR_RES_LO: next_res_lo = pwdata[7:0];
        ADDR_STATUS: if (pwdata[STAT_DONE]) next_r.done = 1'b0;
        default:     ; // unmapped write ignored
      endcase
    end
    if (rd_en)
    begin
      case (paddr)
        ADDR_CTRL0:  next_r.prdata = {24'h0, r.ctrl0};
        ADDR_PINCFG: next_r.prdata = {24'h0, r.pincfg};
        ADDR_CTRL2:  next_r.prdata = {24'h0, r.ctrl2};
        ADDR_RES_HI: next_r.prdata = {24'h0, res_hi};
        ADDR_RES_LO: next_r.prdata = {24'h0, res_lo};
        ADDR_STATUS: next_r.prdata = {31'h0, r.done};
        default:     next_r.prdata = 32'h0000_0000;
      endcase
    end
    // go accepted only while on
    if (!next_r.ctrl0[CTRL0_ON])
      next_r.ctrl0[CTRL0_GO] = 1'b0;
    // sequencer
    case (r.st)
      ST_IDLE:
      begin
        if (go_wr && r.ctrl0[CTRL0_ON])
        begin
          next_r.per_cnt = acq_periods(r.ctrl2[CTRL2_ACQ +: 3]);
          next_r.dly_cnt = TCY_CLOCKS;
          // restart the bit-period phase so every period is whole
          next_r.div_cnt = 7'h00;
          next_r.rc_cnt  = 10'h000;
          if (is_rc)
            next_r.st = ST_DLY;
          else if (acq_periods(r.ctrl2[CTRL2_ACQ +: 3]) == 5'h00)
          begin
            next_r.st      = ST_CONV;
            next_r.per_cnt = CONV_PERIODS;
          end
          else
            next_r.st = ST_ACQ;
        end
        else if (go_wr)
          next_r.ctrl0[CTRL0_GO] = 1'b0;
      end
      ST_DLY:
      begin
        next_r.dly_cnt = r.dly_cnt - 2'h1;
        next_r.rc_cnt  = 10'h000; // RC clock starts after delay
        if (r.dly_cnt == 2'h0)
        begin
          if (r.per_cnt == 5'h00)
          begin
            next_r.st      = ST_CONV;
            next_r.per_cnt = CONV_PERIODS;
          end
          else
            next_r.st = ST_ACQ;
        end
      end
      ST_ACQ:
      begin
        if (tick)
        begin
          next_r.per_cnt = r.per_cnt - 5'h01;
          if (r.per_cnt == 5'h01)
          begin
            next_r.st      = ST_CONV;
            next_r.per_cnt = CONV_PERIODS;
          end
        end
      end
      ST_CONV:
      begin
        if (tick)
        begin
          next_r.per_cnt = r.per_cnt - 5'h01;
          if (r.per_cnt == 5'h01)
          begin
            // result, go clear and flag in one cycle
            next_r.ctrl0[CTRL0_GO] = 1'b0;
            next_r.done            = 1'b1;
            next_r.st              = ST_WAIT;
            next_r.per_cnt         = WAIT_PERIODS;
            if (r.ctrl2[CTRL2_FMT])
            begin
              next_res_hi = {6'h00, value[9:8]};
              next_res_lo = value[7:0];
            end
            else
            begin
              next_res_hi = value[9:2];
              next_res_lo = {value[1:0], 6'h00};
            end
          end
        end
      end
      ST_WAIT:
      begin
        next_r.ctrl0[CTRL0_GO] = r.ctrl0[CTRL0_GO] & ~go_wr;
        if (tick)
        begin
          next_r.per_cnt = r.per_cnt - 5'h01;
          if (r.per_cnt == 5'h01)
            next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    // abort on go clear or off keeps the result unless it meets the last conversion tick
    if (r.st != ST_IDLE && r.st != ST_WAIT &&
        (go_clr || !next_r.ctrl0[CTRL0_ON]))
    begin
      next_r.st      = ST_WAIT;
      next_r.per_cnt = WAIT_PERIODS;
    end
    if (!next_r.ctrl0[CTRL0_ON])
      next_r.st = ST_IDLE;
    // single go bit for acquire and convert
    if (next_r.st == ST_DLY || next_r.st == ST_ACQ || next_r.st == ST_CONV)
      next_r.ctrl0[CTRL0_GO] = 1'b1;
    // flag set wins over clear
    if (r.st == ST_CONV && next_r.st == ST_WAIT && next_r.done)
      next_r.done = 1'b1;
    // outputs
    next_r.pin_in = pin_level & next_r.pincfg[6:0];
    next_r.mux    = next_r.ctrl0[CTRL0_CHS +: 3];
    next_r.mux_ok = (next_r.ctrl0[CTRL0_CHS +: 3] != CHAN_NONE);
    next_r.conv   = (next_r.st == ST_CONV);
    next_r.shs    = next_r.ctrl0[CTRL0_ON] &&
                    (next_r.st == ST_IDLE || next_r.st == ST_ACQ ||
                     next_r.st == ST_DLY);
  end

  // state register; result pair keeps value through reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r.ctrl0   <= CTRL0_RST;
      r.pincfg  <= PINCFG_RST;
      r.ctrl2   <= CTRL2_RST;
      r.done    <= 1'b0;
      r.st      <= ST_IDLE;
      r.div_cnt <= 7'h00;
      r.rc_cnt  <= 10'h000;
      r.dly_cnt <= 2'h0;
      r.per_cnt <= 5'h00;
      r.prdata  <= 32'h0000_0000;
      r.pready  <= 1'b0;
      r.pslverr <= 1'b0;
      r.pin_in  <= 7'h00;
      r.mux     <= 3'h0;
      r.mux_ok  <= 1'b1;
      r.shs     <= 1'b0;
      r.conv    <= 1'b0;
    end
    else
    begin
      r.ctrl0   <= next_r.ctrl0;
      r.pincfg  <= next_r.pincfg;
      r.ctrl2   <= next_r.ctrl2;
      r.done    <= next_r.done;
      r.st      <= next_r.st;
      r.div_cnt <= next_r.div_cnt;
      r.rc_cnt  <= next_r.rc_cnt;
      r.dly_cnt <= next_r.dly_cnt;
      r.per_cnt <= next_r.per_cnt;
      r.prdata  <= next_r.prdata;
      r.pready  <= next_r.pready;
      r.pslverr <= next_r.pslverr;
      r.pin_in  <= next_r.pin_in;
      r.mux     <= next_r.mux;
      r.mux_ok  <= next_r.mux_ok;
      r.shs     <= next_r.shs;
      r.conv    <= next_r.conv;
    end
  end

  // result pair: no reset at all
  always_ff @(posedge pclk)
  begin
    res_hi <= next_res_hi;
    res_lo <= next_res_lo;
  end

  // output drive
  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign mux_select     = r.mux;
  assign mux_valid      = r.mux_ok;
  assign sh_sample      = r.shs;
  assign conv_active    = r.conv;
  assign ref_select     = r.ctrl0[CTRL0_REF +: 2];
  assign converter_on   = r.ctrl0[CTRL0_ON];
  assign pin_digital_in = r.pin_in;
  assign conv_done_flag = r.done;

  // assertions
  property p_go_busy;
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_ACQ || r.st == ST_CONV) |-> r.ctrl0[CTRL0_GO];
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("go low while busy");

  property p_off_idle;
    @(posedge pclk) disable iff (!presetn)
    !converter_on |-> r.st == ST_IDLE && !conv_active;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("busy while off");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
    $rose(conv_done_flag) |-> !r.ctrl0[CTRL0_GO] && !conv_active;
  endproperty
  a_done: assert property (p_done)
    else $error("flag set while still busy");

  sequence s_finish;
    r.st == ST_CONV && tick && r.per_cnt == 5'h01 && !go_clr &&
    converter_on;
  endsequence
  property p_complete;
    @(posedge pclk) disable iff (!presetn)
    s_finish |=> conv_done_flag && !r.ctrl0[CTRL0_GO] && r.st == ST_WAIT;
  endproperty
  a_complete: assert property (p_complete)
    else $error("completion not signalled");

  property p_wait2;
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_CONV ##1 r.st == ST_WAIT) |-> r.per_cnt == WAIT_PERIODS;
  endproperty
  a_wait2: assert property (p_wait2)
    else $error("wait length wrong");

  property p_zero_acq;
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_IDLE && go_wr && converter_on && pwdata[CTRL0_ON] && !is_rc &&
     r.ctrl2[CTRL2_ACQ +: 3] == 3'h0) |=> r.st == ST_CONV;
  endproperty
  a_zero_acq: assert property (p_zero_acq)
    else $error("no immediate conversion");

  property p_conv_len;
    @(posedge pclk) disable iff (!presetn)
    (r.st != ST_CONV ##1 r.st == ST_CONV) |-> r.per_cnt == CONV_PERIODS;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_CONV && go_clr && pwdata[CTRL0_ON] && converter_on &&
     !(tick && r.per_cnt == 5'h01)) |=>
      $stable(res_hi) && $stable(res_lo) && r.st == ST_WAIT &&
      !$rose(conv_done_flag);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort changed result");

  property p_pins;
    @(posedge pclk) disable iff (!presetn)
    (pin_digital_in & ~r.pincfg[6:0]) == 7'h00;
  endproperty
  a_pins: assert property (p_pins)
    else $error("analog pin reads high");

endmodule : aacc_top
`default_nettype wire

// >>> test_adc_acquire_convert_control.sv
// test_adc_acquire_convert_control: self-checking bench for aacc_top
// assumes aacc_analog_model on the far side and RC_DIV set to 4
`timescale 1ns/100ps
`default_nettype none
module test_adc_acquire_convert_control;
  import aacc_pkg::*;
  // design signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  sample_value;
  logic [6:0]  pin_level, pin_drive, pin_digital_in;
  logic [2:0]  mux_select;
  logic [1:0]  ref_select;
  logic        mux_valid, sh_sample, conv_active, converter_on;
  logic        conv_done_flag, err;
  // bench state
  logic [69:0] chan_levels;
  logic [31:0] lfsr;
  int          num_errors = 0, n_compared = 0, cyc = 0, nconv = 0;
  int          t0, n0, p, v, e;
  int          per[8] = '{2, 8, 32, 4, 4, 16, 64, 4}; // cycles per period
  int          acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // acquisition periods
  logic [7:0]  msk[3] = '{CTRL0_MASK, PINCFG_MASK, CTRL2_MASK};
  // design and analog side
  aacc_top #(.RC_DIV(4)) aacc_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_value(sample_value), .pin_level(pin_level),
    .mux_select(mux_select), .mux_valid(mux_valid), .sh_sample(sh_sample),
    .conv_active(conv_active), .ref_select(ref_select),
    .converter_on(converter_on), .pin_digital_in(pin_digital_in),
    .conv_done_flag(conv_done_flag));
  aacc_analog_model aacc_analog_model_i (.pclk(pclk),
    .chan_levels(chan_levels), .pin_drive(pin_drive),
    .mux_select(mux_select), .mux_valid(mux_valid), .sh_sample(sh_sample),
    .conv_active(conv_active), .sample_value(sample_value),
    .pin_level(pin_level));
  // random source
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0400_0007 : 32'h0000_0000);
    return lfsr;
  endfunction : rnd
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // verdict
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // cycle and conversion counters
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (conv_active === 1'b1)
      nconv <= nconv + 1;
  end
  // hang guard
  initial
  begin
    #400000;
    num_errors++;
    test_done();
  end
  // wait for a level on a design output, bounded only by the hang guard
  task automatic wait_hi(ref logic s);
    while (s !== 1'b1)
      @(posedge pclk);
  endtask : wait_hi
  // main sequence
  initial
  begin
    lfsr        = 32'h933d_9b1a;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    pin_drive   = 7'h00;
    chan_levels = 70'({rnd(), rnd(), rnd()});
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then reserved bits read zero
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b1, 8'(4 * i), 32'hffff_fffd);
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'(msk[i] & 8'hfd));
    end
    check(32'({converter_on, ref_select, mux_valid}), 32'he);
    // unmapped place refused
    apb(1'b0, 8'h18, 32'h0);
    check(32'({err, rd[7:0]}), 32'h100);
    // digital pin gating
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      apb(1'b1, ADDR_PINCFG, 32'(v[6:0]));
      pin_drive <= v[14:8];
      repeat (3) @(posedge pclk);
      check(32'(pin_digital_in), 32'(v[6:0] & v[14:8]));
    end
    // each clock, acquisition and channel code once, each format code four times
    for (int i = 0; i < 8; i++)
    begin
      p = per[i];
      apb(1'b1, ADDR_CTRL2, 32'({i[0], 1'b0, i[2:0], i[2:0]}));
      apb(1'b0, ADDR_CTRL2, 32'h0);
      check(rd, 32'({i[0], 1'b0, i[2:0], i[2:0]}));
      apb(1'b1, ADDR_CTRL0, 32'({i[1:0], 1'b0, i[2:0], 2'b01}));
      repeat (30) @(posedge pclk); // software settles the channel
      check(32'({mux_valid, mux_select, ref_select, converter_on, sh_sample}),
            32'({i != 7, i[2:0], i[1:0], 2'b11}));
      v = (i == 7) ? 1023 : int'(chan_levels[(i % 7) * 10 +: 10]);
      n0 = nconv;
      apb(1'b1, ADDR_CTRL0, 32'({i[1:0], 1'b0, i[2:0], 2'b11}));
      t0 = cyc;
      apb(1'b0, ADDR_CTRL0, 32'h0);
      check(32'(rd[1]), 32'h1);
      wait_hi(conv_active);
      e = acq[i] * p + ((i % 4 == 3) ? 4 : 0);
      check(32'(cyc - t0 >= e - 2 && cyc - t0 <= e + p + 8), 1);
      check(32'(sh_sample), 32'h0);
      wait_hi(conv_done_flag);
      check(32'(nconv - n0 > 10 * p && nconv - n0 <= 11 * p + 1), 1);
      apb(1'b0, ADDR_CTRL0, 32'h0);
      check(32'(rd[1]), 32'h0);
      apb(1'b0, ADDR_RES_HI, 32'h0);
      check(rd, 32'(i[0] ? v >> 8 : v >> 2));
      apb(1'b0, ADDR_RES_LO, 32'h0);
      check(rd, 32'(i[0] ? v & 255 : (v & 3) << 6));
      if (p >= 16)
      begin
        apb(1'b1, ADDR_CTRL0, 32'({i[1:0], 1'b0, i[2:0], 2'b11}));
        apb(1'b0, ADDR_CTRL0, 32'h0);
        check(32'(rd[1]), 32'h0);
      end
      repeat (3 * p) @(posedge pclk);
      check(32'({sh_sample, conv_active}), 32'h2);
      apb(1'b1, ADDR_STATUS, 32'h1);
      check(32'(conv_done_flag), 32'h0);
    end
    // abort in mid conversion keeps the last result
    apb(1'b1, ADDR_CTRL2, 32'h86);
    apb(1'b1, ADDR_CTRL0, 32'h3);
    repeat (100) @(posedge pclk);
    apb(1'b1, ADDR_CTRL0, 32'h1);
    repeat (20) @(posedge pclk);
    check(32'({conv_active, conv_done_flag}), 32'h0);
    apb(1'b0, ADDR_RES_HI, 32'h0);
    check(rd, 32'h3);
    // reset in mid conversion, once the post-abort wait is over
    repeat (150) @(posedge pclk);
    apb(1'b1, ADDR_CTRL0, 32'h3);
    repeat (100) @(posedge pclk);
    check(32'(conv_active), 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'({conv_active, converter_on}), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL0, 32'h0);
    check(rd, 32'(CTRL0_RST));
    apb(1'b0, ADDR_RES_LO, 32'h0);
    check(rd, 32'hff);
    test_done();
  end
endmodule : test_adc_acquire_convert_control
`default_nettype wire
